// file: common/rtc_pkg.sv
// Constants and types shared by the thermostat control files.
// How it works
// - Knob zero with enable gives standby, steady LED.
// - Otherwise ON state, full control, flashing LED.
// - Eco raises setpoint, uses eco hysteresis.
// - Door input: eco after delays, normal on opening.
// - Zero door or timeout delay disables that path.
// - Input acts only after programmed input delay.
// - Door open starts alarm delay, leaves eco.
// - Function three locks compressor until door alarm.
// - Function four alarms; five also disables output.
// - Function six selects eco while input closed.
// - Function seven: closed means ON, open standby.
// - Negative function inverts polarity; zero, eight inactive.
// - Output is on/off against setpoint and hysteresis.
// - Probe error cycles output on then off.
// - Zero on time keeps off; zero off keeps on.
// - Switch-on delay; all protections must be expired.
// - Minimum off time after last switch-off.
// - Minimum interval between two switch-ons.
// - Power-on delay holds output; zero disables it.
// - Interval defrost, own first time, zero disables.
// - Defrost stops compressor for defrost duration.
// - Continuous run time also starts a defrost.
package rtc_pkg;
    localparam int TW = 20;
    localparam int DW = 16;
    localparam int AW = DW + 2;
    localparam int PW = 28;
    localparam int CLK_MHZ = 250;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_CYC = TICK_PERIOD_S * CLK_MHZ * 1000000;
    localparam logic [3:0] FN_DOOR1 = 4'h1;
    localparam logic [3:0] FN_DOOR2 = 4'h2;
    localparam logic [3:0] FN_DOOR_LOCK = 4'h3;
    localparam logic [3:0] FN_EXT = 4'h4;
    localparam logic [3:0] FN_EXT_LOCK = 4'h5;
    localparam logic [3:0] FN_ECO = 4'h6;
    localparam logic [3:0] FN_ONOFF = 4'h7;
    localparam logic [3:0] KNOB_STANDBY_POS = 4'h0;
    localparam int T_DI = 0;
    localparam int T_DOOR = 1;
    localparam int T_ECOD = 2;
    localparam int T_ECOT = 3;
    localparam int T_EON = 4;
    localparam int T_EOFF = 5;
    localparam int T_P1 = 6;
    localparam int T_P2 = 7;
    localparam int T_P3 = 8;
    localparam int T_POR = 9;
    localparam int T_DINT = 10;
    localparam int T_DDUR = 11;
    localparam int T_CRUN = 12;
    localparam int NT = 13;
    typedef enum logic [1:0] {PE_IDLE, PE_ON, PE_OFF} rtc_perr_e;
endpackage

// file: design/rtc_timer.sv
// Seconds down-counter used for every delay of the thermostat.
`timescale 1ns/10ps
module rtc_timer
    import rtc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic start,
    input wire logic [TW-1:0] len,
    output logic busy,
    output logic done
);
    logic [TW-1:0] cnt_r;
    logic [TW-1:0] cnt_nxt;

    // A start reloads the count; a zero length leaves the timer idle.
    always_comb begin
        cnt_nxt = cnt_r;
        if (start) begin
            cnt_nxt = len;
        end else if (tick && cnt_r != '0) begin
            cnt_nxt = cnt_r - TW'(1);
        end
    end

    // The count register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Busy while counting; done on the tick that reaches zero.
    assign busy = cnt_r != '0;
    // Done does not look at start, so a timer that reloads itself on its
    // own expiry forms no combinational loop.
    assign done = tick && cnt_r == TW'(1);
endmodule // rtc_timer

// file: design/rtc_thermostat.sv
// Refrigeration thermostat: modes, digital input, control and defrost.
`timescale 1ns/10ps
module rtc_thermostat
    import rtc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic DIGITAL_INPUT,
    input wire logic [3:0] KNOB_POSITION,
    input wire logic KNOB_STANDBY_ENABLE,
    input wire logic signed [4:0] INPUT_FUNCTION_SELECT,
    input wire logic [TW-1:0] INPUT_ACTION_DELAY,
    input wire logic [TW-1:0] DOOR_CLOSED_ECO_DELAY,
    input wire logic [TW-1:0] ECO_TIMEOUT,
    input wire logic [TW-1:0] DOOR_ALARM_DELAY,
    input wire logic signed [DW-1:0] CELL_PROBE,
    input wire logic PROBE_ERROR,
    input wire logic signed [DW-1:0] PROBE_CALIBRATION_OFFSET,
    input wire logic signed [DW-1:0] SETPOINT,
    input wire logic signed [DW-1:0] ECO_SETPOINT_OFFSET,
    input wire logic signed [DW-1:0] NORMAL_HYSTERESIS,
    input wire logic signed [DW-1:0] ECO_HYSTERESIS,
    input wire logic [TW-1:0] PROBE_ERROR_ON_TIME,
    input wire logic [TW-1:0] PROBE_ERROR_OFF_TIME,
    input wire logic [TW-1:0] SWITCH_ON_DELAY,
    input wire logic [TW-1:0] MIN_OFF_TIME,
    input wire logic [TW-1:0] MIN_ON_TO_ON_TIME,
    input wire logic [TW-1:0] POWER_ON_DELAY,
    input wire logic [TW-1:0] DEFROST_INTERVAL,
    input wire logic [TW-1:0] FIRST_DEFROST_TIME,
    input wire logic [TW-1:0] DEFROST_DURATION,
    input wire logic [TW-1:0] CONTINUOUS_RUN_TIME,
    output logic COMPRESSOR_OUT,
    output logic GREEN_LED,
    output logic STANDBY,
    output logic ECO_ACTIVE,
    output logic DOOR_ALARM,
    output logic EXT_ALARM,
    output logic DEFROST_ACTIVE
);
    logic [PW-1:0] pre_r, pre_nxt;
    logic tick_r, tick_nxt;
    logic s1_r, s2_r, s3_r, di_r, di_nxt;
    logic di_del_r, di_del_nxt;
    logic door_prev_r, door_alarm_r, door_alarm_nxt;
    logic ext_alarm_r, ext_alarm_nxt;
    logic eco_r, eco_nxt, standby_r, standby_nxt;
    logic demand_r, demand_nxt, req_prev_r, out_r, out_nxt;
    logic first_r, flash_r, flash_nxt, green_r, green_nxt;
    logic defrost_r;
    rtc_perr_e pe_r, pe_nxt;
    logic [NT-1:0] start, busy, done;
    logic [TW-1:0] len [NT];
    logic inv, act, door_fn, door_open, lock, ext_lock;
    logic err_req, req, p1_ok, inhibit, dfr_go;
    logic [4:0] fabs;
    logic [3:0] fn;
    logic signed [AW-1:0] temp, sp, hy;

    // One seconds timer per delay; all share the same tick.
    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++) begin : g_tmr
            rtc_timer u_tmr (
                .clk(CLK),
                .rst_n(RST_N),
                .tick(tick_r),
                .start(start[gi]),
                .len(len[gi]),
                .busy(busy[gi]),
                .done(done[gi])
            );
        end
    endgenerate

    // Timer lengths from the settings; the defrost interval timer takes FIRST_DEFROST_TIME on its first start.
    always_comb begin
        len[T_DI] = INPUT_ACTION_DELAY;
        len[T_DOOR] = DOOR_ALARM_DELAY;
        len[T_ECOD] = DOOR_CLOSED_ECO_DELAY;
        len[T_ECOT] = ECO_TIMEOUT;
        len[T_EON] = PROBE_ERROR_ON_TIME;
        len[T_EOFF] = PROBE_ERROR_OFF_TIME;
        len[T_P1] = SWITCH_ON_DELAY;
        len[T_P2] = MIN_OFF_TIME;
        len[T_P3] = MIN_ON_TO_ON_TIME;
        len[T_POR] = POWER_ON_DELAY;
        // An immediate first defrost still arms the regular interval.
        len[T_DINT] = (first_r && FIRST_DEFROST_TIME != '0) ?
            FIRST_DEFROST_TIME : DEFROST_INTERVAL;
        len[T_DDUR] = DEFROST_DURATION;
        len[T_CRUN] = CONTINUOUS_RUN_TIME;
    end

    // Decoding of the input function and the corrected probe reading.
    always_comb begin
        inv = INPUT_FUNCTION_SELECT < 0;
        fabs = inv ? 5'(-INPUT_FUNCTION_SELECT) : INPUT_FUNCTION_SELECT;
        fn = fabs[3:0];
        act = di_r ^ inv;
        door_fn = fn == FN_DOOR1 || fn == FN_DOOR2 || fn == FN_DOOR_LOCK;
        door_open = door_fn && di_del_r;
        lock = door_open && fn == FN_DOOR_LOCK && !door_alarm_r;
        ext_lock = ext_alarm_r && fn == FN_EXT_LOCK;
        temp = AW'(CELL_PROBE) + AW'(PROBE_CALIBRATION_OFFSET);
        sp = AW'(SETPOINT) + (eco_r ? AW'(ECO_SETPOINT_OFFSET) : '0);
        hy = eco_r ? AW'(ECO_HYSTERESIS) : AW'(NORMAL_HYSTERESIS);
    end

    // Next state of the whole control path.
    always_comb begin
        start = '0;
        tick_nxt = pre_r == PW'(TICK_CYCLES - 1);
        pre_nxt = tick_nxt ? '0 : pre_r + PW'(1);
        // Debounced contact follows once the last two samples agree.
        di_nxt = (s2_r == s3_r) ? s3_r : di_r;
        start[T_DI] = di_nxt != di_r;
        di_del_nxt = di_del_r;
        if (!busy[T_DI] && !start[T_DI]) begin
            di_del_nxt = act;
        end
        // Door alarm after its delay while the door stays open.
        start[T_DOOR] = door_open && !door_prev_r;
        door_alarm_nxt = door_open && (door_alarm_r ||
            (!busy[T_DOOR] && !start[T_DOOR]));
        ext_alarm_nxt = (fn == FN_EXT || fn == FN_EXT_LOCK) && di_del_r;
        // Eco selection by door timers or by the eco input function.
        start[T_ECOD] = door_fn && door_prev_r && !door_open;
        start[T_ECOT] = start[T_ECOD];
        eco_nxt = eco_r;
        if (fn == FN_ECO) begin
            eco_nxt = di_del_r;
        end else if (!door_fn || door_open) begin
            eco_nxt = 1'b0;
        end else if (done[T_ECOD] || done[T_ECOT]) begin
            eco_nxt = 1'b1;
        end
        standby_nxt = (KNOB_STANDBY_ENABLE &&
            KNOB_POSITION == KNOB_STANDBY_POS) ||
            (fn == FN_ONOFF && !di_del_r);
        // Cooling demand with hysteresis above the setpoint.
        demand_nxt = demand_r;
        if (temp >= sp + hy) begin
            demand_nxt = 1'b1;
        end else if (temp <= sp) begin
            demand_nxt = 1'b0;
        end
        // Probe error cycling of the request.
        pe_nxt = pe_r;
        case (pe_r)
            PE_IDLE: begin
                if (PROBE_ERROR) begin
                    pe_nxt = PE_ON;
                    start[T_EON] = 1'b1;
                end
            end
            PE_ON: begin
                if (!busy[T_EON] && PROBE_ERROR_OFF_TIME != '0) begin
                    pe_nxt = PE_OFF;
                    start[T_EOFF] = 1'b1;
                end
            end
            default: begin
                if (!busy[T_EOFF]) begin
                    pe_nxt = PE_ON;
                    start[T_EON] = 1'b1;
                end
            end
        endcase
        if (!PROBE_ERROR) begin
            pe_nxt = PE_IDLE;
        end
        err_req = PROBE_ERROR_ON_TIME != '0 &&
            (PROBE_ERROR_OFF_TIME == '0 || pe_r == PE_ON);
        req = !standby_r && (PROBE_ERROR ? err_req : demand_r);
        start[T_P1] = req && !req_prev_r;
        p1_ok = !busy[T_P1] && !start[T_P1];
        // Defrost from interval, first-defrost time or long running.
        dfr_go = DEFROST_INTERVAL != '0 && ((first_r &&
            FIRST_DEFROST_TIME == '0) || done[T_DINT] ||
            (done[T_CRUN] && out_r));
        start[T_DINT] = DEFROST_INTERVAL != '0 &&
            (first_r || done[T_DINT]);
        start[T_DDUR] = dfr_go;
        // A defrost that starts now already holds the output off.
        inhibit = standby_r || lock || ext_lock || busy[T_DDUR] ||
            dfr_go || busy[T_P2] || busy[T_P3] || busy[T_POR] ||
            !p1_ok;
        out_nxt = req && !inhibit;
        start[T_P2] = out_r && !out_nxt;
        start[T_P3] = !out_r && out_nxt;
        start[T_CRUN] = start[T_P3];
        start[T_POR] = first_r;
        flash_nxt = tick_r ? !flash_r : flash_r;
        green_nxt = standby_nxt ? 1'b1 : flash_nxt;
    end

    // Registers of the control path.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pre_r <= '0;
            tick_r <= 1'b0;
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            di_r <= 1'b0;
            di_del_r <= 1'b0;
            door_prev_r <= 1'b0;
            door_alarm_r <= 1'b0;
            ext_alarm_r <= 1'b0;
            eco_r <= 1'b0;
            standby_r <= 1'b0;
            demand_r <= 1'b0;
            pe_r <= PE_IDLE;
            req_prev_r <= 1'b0;
            out_r <= 1'b0;
            first_r <= 1'b1;
            flash_r <= 1'b0;
            green_r <= 1'b0;
            defrost_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            tick_r <= tick_nxt;
            s1_r <= DIGITAL_INPUT;
            s2_r <= s1_r;
            s3_r <= s2_r;
            di_r <= di_nxt;
            di_del_r <= di_del_nxt;
            door_prev_r <= door_open;
            door_alarm_r <= door_alarm_nxt;
            ext_alarm_r <= ext_alarm_nxt;
            eco_r <= eco_nxt;
            standby_r <= standby_nxt;
            demand_r <= demand_nxt;
            pe_r <= pe_nxt;
            req_prev_r <= req;
            out_r <= out_nxt;
            first_r <= 1'b0;
            flash_r <= flash_nxt;
            green_r <= green_nxt;
            defrost_r <= busy[T_DDUR] || start[T_DDUR];
        end
    end

    // Outputs all come from registers.
    assign COMPRESSOR_OUT = out_r;
    assign GREEN_LED = green_r;
    assign STANDBY = standby_r;
    assign ECO_ACTIVE = eco_r;
    assign DOOR_ALARM = door_alarm_r;
    assign EXT_ALARM = ext_alarm_r;
    assign DEFROST_ACTIVE = defrost_r;

    // Checks on the control path.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_standby_out_off: assert property (standby_r |=> !out_r)
        else $error("output on during standby");
    a_standby_led_on: assert property (standby_r |-> green_r)
        else $error("green led not steady in standby");
    a_on_not_standby: assert property (
        !KNOB_STANDBY_ENABLE && fn != FN_ONOFF |=> !standby_r)
        else $error("standby without a cause");
    a_eco_input_sel: assert property (
        fn == FN_ECO |=> eco_r == $past(di_del_r))
        else $error("eco does not follow input");
    a_door_leaves_eco: assert property (door_open |=> !eco_r)
        else $error("eco kept while door open");
    a_door_lock_off: assert property (lock |=> !out_r)
        else $error("compressor on while door locked");
    a_ext_lock_off: assert property (ext_lock |=> !out_r)
        else $error("output on during external lock");
    a_min_off_hold: assert property (
        $fell(out_r) && MIN_OFF_TIME != '0 |-> !out_r [*8])
        else $error("output back on inside minimum off time");
    a_on_to_on_hold: assert property (
        $rose(out_r) && MIN_ON_TO_ON_TIME != '0 |=> !$rose(out_r) [*8])
        else $error("two switch-ons inside minimum interval");
    a_power_on_hold: assert property (busy[T_POR] |=> !out_r)
        else $error("output on during power-on delay");
    a_defrost_stops: assert property (defrost_r |-> !out_r)
        else $error("compressor on during defrost");
    a_err_stays_off: assert property (
        PROBE_ERROR && PROBE_ERROR_ON_TIME == '0 |=> !out_r)
        else $error("output on in probe error with zero on time");
    a_demand_rises: assert property (
        temp >= sp + hy |=> demand_r)
        else $error("no demand above setpoint plus hysteresis");

    c_defrost_start: cover property ($rose(defrost_r));
    c_door_alarm: cover property ($rose(door_alarm_r));
    c_eco_entry: cover property ($rose(eco_r) && door_fn);
    c_compressor_on: cover property ($rose(out_r));
endmodule // rtc_thermostat

// file: dv/rtc_plant.sv
// Plant model: bouncing door or alarm contact and the cell probe.
`timescale 1ns/10ps
module rtc_plant
    import rtc_pkg::*;
#(
    parameter int BOUNCE = 6
)
(
    input wire logic clk,
    input wire logic active,
    input wire logic contact_nc,
    input wire logic signed [DW-1:0] temp,
    input wire logic fault,
    output logic signed [DW-1:0] probe,
    output logic probe_err,
    output logic contact
);
    logic level_r = 1'b0;
    int bounce_r = 0;
    // Contact and probe start from a known level.
    initial begin
        contact = 1'b0;
        probe = 16'sh0;
    end
    // A moved contact chatters each cycle before it settles.
    always @(posedge clk) begin
        if ((active ^ contact_nc) != level_r) begin
            level_r <= active ^ contact_nc;
            bounce_r <= BOUNCE;
        end else if (bounce_r > 0) begin
            bounce_r <= bounce_r - 1;
        end
        contact <= (bounce_r > 0) ? ~contact : level_r;
        probe_err <= fault;
        probe <= fault ? ~probe : temp; // A broken probe reads garbage.
    end
endmodule // rtc_plant

// file: dv/tb.sv
// Self-checking testbench of the thermostat control.
`timescale 1ns/10ps
module tb import rtc_pkg::*;;
    localparam int TK = 4;
    localparam int CMP = 0, DAL = 1, XAL = 2, ECO = 3, STB = 4, DFR = 5;
    logic clk = 1'b0, rst_n = 1'b0, active = 1'b0, nc = 1'b0;
    logic fault = 1'b0, ksb = 1'b0, contact, perr, l;
    logic comp, led, stby, eco, dal, xal, dfr;
    logic [3:0] knob = 4'h3;
    logic signed [4:0] fsel = 5'sh0;
    logic signed [DW-1:0] probe, temp = 16'sh32, cal = 16'sh0a;
    logic signed [DW-1:0] sp = 16'sh28, hyst = 16'sh14;
    logic signed [DW-1:0] eoff = 16'sh1e, ehys = 16'sh05;
    logic [TW-1:0] t_di = 20'h0, t_door = 20'h6, t_ecod = 20'h4;
    logic [TW-1:0] t_ecot = 20'h0, t_eon = 20'h0, t_eoff = 20'h0;
    logic [TW-1:0] t_p1 = 20'h0, t_p2 = 20'h0, t_p3 = 20'h0;
    logic [TW-1:0] t_por = 20'h5, t_dint = 20'h0, t_dsd = 20'h0;
    logic [TW-1:0] t_ddur = 20'h3, t_crun = 20'h0;
    int mismatches = 0, comparisons = 0, cycles = 0, n;
    rtc_plant rtc_plant_inst (
        .clk(clk), .active(active), .contact_nc(nc), .temp(temp),
        .fault(fault), .probe(probe), .probe_err(perr), .contact(contact)
    );
    rtc_thermostat #(.TICK_CYCLES(TK)) rtc_thermostat_inst (
        .CLK(clk), .RST_N(rst_n), .DIGITAL_INPUT(contact),
        .KNOB_POSITION(knob), .KNOB_STANDBY_ENABLE(ksb),
        .INPUT_FUNCTION_SELECT(fsel), .INPUT_ACTION_DELAY(t_di),
        .DOOR_CLOSED_ECO_DELAY(t_ecod), .ECO_TIMEOUT(t_ecot),
        .DOOR_ALARM_DELAY(t_door), .CELL_PROBE(probe), .PROBE_ERROR(perr),
        .PROBE_CALIBRATION_OFFSET(cal), .SETPOINT(sp),
        .ECO_SETPOINT_OFFSET(eoff), .NORMAL_HYSTERESIS(hyst),
        .ECO_HYSTERESIS(ehys), .PROBE_ERROR_ON_TIME(t_eon),
        .PROBE_ERROR_OFF_TIME(t_eoff), .SWITCH_ON_DELAY(t_p1),
        .MIN_OFF_TIME(t_p2), .MIN_ON_TO_ON_TIME(t_p3),
        .POWER_ON_DELAY(t_por), .DEFROST_INTERVAL(t_dint),
        .FIRST_DEFROST_TIME(t_dsd), .DEFROST_DURATION(t_ddur),
        .CONTINUOUS_RUN_TIME(t_crun), .COMPRESSOR_OUT(comp),
        .GREEN_LED(led), .STANDBY(stby), .ECO_ACTIVE(eco),
        .DOOR_ALARM(dal), .EXT_ALARM(xal), .DEFROST_ACTIVE(dfr)
    );
    // Clock of 4 ns, and a ceiling that cuts a hung run short.
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            mismatches++;
            give_verdict();
        end
    end
    // Bench helpers: stepping, watching and comparing.
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    function automatic logic sig(input int s);
        case (s)
            CMP: return comp;
            DAL: return dal;
            XAL: return xal;
            ECO: return eco;
            STB: return stby;
            DFR: return dfr;
            default: return led;
        endcase
    endfunction
    task automatic chk(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %b not %b", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int k, input int lo, input int hi);
        comparisons++;
        if (k < lo || k > hi) begin
            mismatches++;
            $display("Error at %0t: %0d cycles elapsed", $time, k);
        end
    endtask
    task automatic wait_sig(input int s, input logic lvl, output int k);
        k = 0;
        while (sig(s) !== lvl && k < 300) begin
            step(1);
            k++;
        end
        chk(sig(s), lvl);
    endtask
    task automatic hold(input int s, input logic lvl, input int k);
        repeat (k) begin
            step(1);
            chk(sig(s), lvl);
        end
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        step(6);
        rst_n = 1'b1;
    endtask
    task automatic drive(input logic on);
        temp = on ? 16'sh3c : 16'sh14;
        wait_sig(CMP, on, n);
    endtask
    // Power-on hold, then on/off around setpoint with calibration.
    task automatic test_cooling();
        wait_sig(CMP, 1'b1, n);
        chk_rng(n, 14, 28);
        temp = 16'sh2d;
        hold(CMP, 1'b1, 12);
        temp = 16'sh1e;
        wait_sig(CMP, 1'b0, n);
        chk_rng(n, 0, 6);
        temp = 16'sh2d;
        hold(CMP, 1'b0, 12);
    endtask
    // Minimum off, on-to-on interval and switch-on delay.
    task automatic test_protect();
        t_p2 = 20'h5;
        drive(1'b1);
        drive(1'b0);
        drive(1'b1);
        chk_rng(n, 14, 26);
        t_p2 = 20'h0;
        t_p3 = 20'h6;
        drive(1'b0);
        drive(1'b1);
        drive(1'b0);
        drive(1'b1);
        chk_rng(n, 8, 26);
        t_p3 = 20'h0;
        t_p1 = 20'h8;
        drive(1'b0);
        drive(1'b1);
        chk_rng(n, 26, 36);
        t_p1 = 20'h0;
    endtask
    // Knob standby with steady indicator, then ON with a blinking one.
    task automatic test_standby();
        drive(1'b1);
        ksb = 1'b1;
        knob = 4'h0;
        wait_sig(STB, 1'b1, n);
        wait_sig(CMP, 1'b0, n);
        hold(6, 1'b1, 12);
        knob = 4'h2;
        wait_sig(STB, 1'b0, n);
        l = led;
        step(TK);
        chk(led, ~l);
        wait_sig(CMP, 1'b1, n);
        ksb = 1'b0;
        knob = 4'h0;
        hold(STB, 1'b0, 8);
    endtask
    // Input delay, external alarm, output lock and inverted contact.
    task automatic test_ext();
        fsel = 5'sh4;
        t_di = 20'h5;
        active = 1'b1;
        step(12);
        active = 1'b0;
        hold(XAL, 1'b0, 40);
        active = 1'b1;
        wait_sig(XAL, 1'b1, n);
        chk_rng(n, 22, 38);
        chk(comp, 1'b1);
        fsel = 5'sh5;
        wait_sig(CMP, 1'b0, n);
        chk_rng(n, 0, 6);
        t_di = 20'h0;
        active = 1'b0;
        nc = 1'b1;
        fsel = -5'sh5;
        step(2);
        hold(XAL, 1'b0, 12);
        active = 1'b1;
        wait_sig(XAL, 1'b1, n);
        fsel = 5'sh8;
        wait_sig(XAL, 1'b0, n);
        active = 1'b0;
        nc = 1'b0;
    endtask
    // Eco select input: raised setpoint and eco hysteresis.
    task automatic test_eco();
        fsel = 5'sh6;
        temp = 16'sh37;
        wait_sig(CMP, 1'b1, n);
        active = 1'b1;
        wait_sig(ECO, 1'b1, n);
        wait_sig(CMP, 1'b0, n);
        temp = 16'sh3e;
        hold(CMP, 1'b0, 10);
        temp = 16'sh42;
        wait_sig(CMP, 1'b1, n);
        chk_rng(n, 0, 6);
        temp = 16'sh3b;
        wait_sig(CMP, 1'b0, n);
        active = 1'b0;
        wait_sig(ECO, 1'b0, n);
    endtask
    // Door with lock: alarm delay, lock release, eco on closing.
    task automatic test_door();
        fsel = 5'sh3;
        wait_sig(CMP, 1'b1, n);
        active = 1'b1;
        wait_sig(CMP, 1'b0, n);
        wait_sig(DAL, 1'b1, n);
        chk_rng(n, 16, 30);
        wait_sig(CMP, 1'b1, n);
        chk_rng(n, 0, 3);
        active = 1'b0;
        wait_sig(ECO, 1'b1, n);
        chk_rng(n, 18, 34);
        active = 1'b1;
        wait_sig(ECO, 1'b0, n);
        chk_rng(n, 6, 18);
        t_ecod = 20'h0;
        t_ecot = 20'h5;
        active = 1'b0;
        wait_sig(ECO, 1'b1, n);
        chk_rng(n, 24, 38);
        active = 1'b1;
        wait_sig(ECO, 1'b0, n);
        t_ecot = 20'h0;
        active = 1'b0;
        hold(ECO, 1'b0, 60);
    endtask
    // On/standby input, then probe error cycling.
    task automatic test_onoff_perr();
        fsel = 5'sh7;
        wait_sig(STB, 1'b1, n);
        active = 1'b1;
        wait_sig(STB, 1'b0, n);
        chk_rng(n, 8, 20);
        fsel = 5'sh0;
        t_eon = 20'h3;
        t_eoff = 20'h2;
        fault = 1'b1;
        wait_sig(CMP, 1'b1, n);
        wait_sig(CMP, 1'b0, n);
        chk_rng(n, 6, 14);
        wait_sig(CMP, 1'b1, n);
        chk_rng(n, 3, 10);
        t_eoff = 20'h0;
        hold(CMP, 1'b1, 40);
        t_eon = 20'h0;
        wait_sig(CMP, 1'b0, n);
        hold(CMP, 1'b0, 40);
        fault = 1'b0;
    endtask
    // Interval, first, immediate and continuous-run defrosts.
    task automatic test_defrost();
        t_dint = 20'ha;
        t_dsd = 20'h3;
        temp = 16'sh3c;
        do_reset();
        wait_sig(DFR, 1'b1, n);
        chk_rng(n, 7, 16);
        wait_sig(CMP, 1'b0, n);
        wait_sig(DFR, 1'b0, n);
        chk_rng(n, 6, 14);
        wait_sig(CMP, 1'b1, n);
        wait_sig(DFR, 1'b1, n);
        chk_rng(n, 10, 44);
        t_dsd = 20'h0;
        do_reset();
        wait_sig(DFR, 1'b1, n);
        chk_rng(n, 0, 3);
        t_dint = 20'h0;
        do_reset();
        hold(DFR, 1'b0, 12);
        t_dint = 20'h64;
        t_dsd = 20'h64;
        t_crun = 20'h5;
        do_reset();
        hold(DFR, 1'b0, 12);
        wait_sig(DFR, 1'b1, n);
        chk_rng(n, 4, 14);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        do_reset();
        test_cooling();
        t_por = 20'h0;
        test_protect();
        test_standby();
        test_ext();
        test_eco();
        test_door();
        test_onoff_perr();
        test_defrost();
        give_verdict();
    end
endmodule // tb
